// *** hdl/pmbus_output_control.v ***
// Notes on behaviour
// - policy 0 runs on power; 1 waits
// - command response bit gates operation on bit
// - pin response bit requires asserted pin
// - rise time exponent -4, top mantissa zero
// - eight rise settings, 600us to 9ms
// - divider ratio: exponent -9, 11-bit mantissa
// - ratio mantissa resets 256, max 512
// - target is 600 mV reference plus trim times ratio
// - trim is signed offset, exponent -10
// - out-of-window trim: zero, alert, status
// - margin levels exponent -10, bit 15 zero
// - margin target is level plus trim, times ratio, no reference
// - operation bits 5:2 select margin mode
// - warn limit exponent -1, six bits writable
// - warn limit 500 mA steps, fixed option
// - temperature status shows fault and warning
// - operation bit 7 is output on
// - config low five bits, given defaults
// - linear word: mantissa times two^exponent
`timescale 1ns/100ps
`include "pmbus_ctrl_consts.vh"

module pmbus_output_control #(
  // 1 holds the warning limit at its fixed value
  parameter FIXED_OC_WARN = 1
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // decoded command port from the bus framer
  input wire i_cmd_valid,
  input wire i_cmd_write,
  input wire [7:0] i_cmd_code,
  input wire [15:0] i_cmd_data,
  output reg [15:0] o_rd_data_r,
  output reg o_rd_valid_r,
  // pins and monitors
  input wire i_power_present,
  input wire i_onoff_pin,
  input wire i_ot_fault,
  input wire i_ot_warn,
  // outputs to the power stage
  output reg o_output_enable_r,
  output wire [27:0] o_vref_target,
  output reg [2:0] o_rise_sel_r,
  output wire [5:0] o_oc_warn_limit,
  output reg o_margin_fault_act_r,
  output wire o_smbalert_n
);

  // synchronisers for the outside pins
  reg power_meta_r;
  reg power_sync_r;
  reg pin_meta_r;
  reg pin_sync_r;

  // command registers
  reg [4:0] power_on_policy_config_r;
  reg [7:0] operation_control_r;
  reg [2:0] soft_start_idx_r;
  reg [10:0] output_divider_ratio_r;
  reg [15:0] output_offset_trim_r;
  reg trim_bad_r; // stored trim lies outside the window
  reg [14:0] margin_high_level_r;
  reg [14:0] margin_low_level_r;
  reg [5:0] oc_warn_r;

  // sticky status
  reg cml_invalid_cmd_r;
  reg cml_invalid_data_r;
  reg temp_fault_r;
  reg temp_warn_r;

  // decode helpers
  wire wr;
  wire rd;
  wire clear_faults;
  wire [3:0] margin_field;
  wire margin_low;
  wire margin_high;
  wire [15:0] trim_eff;
  wire [3:0] rise_lookup;
  wire trim_in_window;
  wire scale_ok;
  wire known_cmd;
  wire pin_asserted;
  wire output_enable_nxt;
  wire [7:0] status_byte;
  wire [7:0] status_cml;
  wire [7:0] status_temp;
  reg [15:0] rd_data_nxt;

  // rise mantissa to setting index, bit 3 marks a listed value
  function [3:0] rise_index;
    input [15:0] word;
    begin
      rise_index = 4'h0;
      if (word[15:11] == `EXP_SOFT_START_TIME) begin
        if (word[10:0] == `TON_M0) rise_index = 4'h8;
        else if (word[10:0] == `TON_M1) rise_index = 4'h9;
        else if (word[10:0] == `TON_M2) rise_index = 4'ha;
        else if (word[10:0] == `TON_M3) rise_index = 4'hb;
        else if (word[10:0] == `TON_M4) rise_index = 4'hc;
        else if (word[10:0] == `TON_M5) rise_index = 4'hd;
        else if (word[10:0] == `TON_M6) rise_index = 4'he;
        else if (word[10:0] == `TON_M7) rise_index = 4'hf;
      end
    end
  endfunction

  // setting index back to its mantissa for read back
  function [10:0] rise_mant;
    input [2:0] idx;
    begin
      case (idx)
        3'h0: rise_mant = `TON_M0;
        3'h1: rise_mant = `TON_M1;
        3'h2: rise_mant = `TON_M2;
        3'h3: rise_mant = `TON_M3;
        3'h4: rise_mant = `TON_M4;
        3'h5: rise_mant = `TON_M5;
        3'h6: rise_mant = `TON_M6;
        default: rise_mant = `TON_M7;
      endcase
    end
  endfunction

  // trim times ratio must stay within 25 % of the reference
  function in_window;
    input [15:0] trim;
    input [10:0] mant;
    reg signed [26:0] p;
    begin
      p = $signed(trim) * $signed({1'b0, mant});
      if (p < 0) begin
        in_window = ((-p) <= $signed(`TRIM_WINDOW_LIM));
      end else begin
        in_window = (p <= $signed(`TRIM_WINDOW_LIM));
      end
    end
  endfunction

  assign wr = i_cmd_valid & i_cmd_write;
  assign rd = i_cmd_valid & ~i_cmd_write;
  assign clear_faults = wr & (i_cmd_code == `CMD_CLEAR_FAULTS);

  assign margin_field = operation_control_r[`OP_MARGIN_MSB:`OP_MARGIN_LSB];
  assign margin_low = (margin_field == `MARGIN_LOW_IGNORE) |
                      (margin_field == `MARGIN_LOW_ACT);
  assign margin_high = (margin_field == `MARGIN_HIGH_IGNORE) |
                       (margin_field == `MARGIN_HIGH_ACT);

  assign trim_eff = trim_bad_r ? `TRIM_RESET : output_offset_trim_r;

  assign rise_lookup = rise_index(i_cmd_data);
  // window check of the signed offset
  assign trim_in_window = in_window(i_cmd_data, output_divider_ratio_r);
  // ratio mantissa from 1 up to 512
  assign scale_ok = (i_cmd_data[15:11] == `EXP_SCALE_LOOP) &
                    (i_cmd_data[10:0] != 11'h000) &
                    (i_cmd_data[10:0] <= `SCALE_MANT_MAX);

  assign known_cmd = (i_cmd_code == `CMD_OPERATION) |
                     (i_cmd_code == `CMD_ON_OFF_CONFIG) |
                     (i_cmd_code == `CMD_CLEAR_FAULTS) |
                     (i_cmd_code == `CMD_VOUT_TRIM) |
                     (i_cmd_code == `CMD_MARGIN_HIGH) |
                     (i_cmd_code == `CMD_MARGIN_LOW) |
                     (i_cmd_code == `CMD_SCALE_LOOP) |
                     (i_cmd_code == `CMD_OC_WARN) |
                     (i_cmd_code == `CMD_SOFT_START_TIME) |
                     (i_cmd_code == `CMD_STATUS_BYTE) |
                     (i_cmd_code == `CMD_STATUS_TEMP) |
                     (i_cmd_code == `CMD_STATUS_CML);

  // two flops on the power and on/off pins before anything looks at them
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      power_meta_r <= 1'b0;
      power_sync_r <= 1'b0;
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
    end else begin
      power_meta_r <= i_power_present;
      power_sync_r <= power_meta_r;
      pin_meta_r <= i_onoff_pin;
      pin_sync_r <= pin_meta_r;
    end
  end

  // polarity 1 means the pin is active high
  assign pin_asserted =
    power_on_policy_config_r[`CFG_PIN_POLARITY] ? pin_sync_r : ~pin_sync_r;

  // policy 0 ignores pin and command
  // bit 7 of operation is on
  assign output_enable_nxt = power_sync_r &
    (~power_on_policy_config_r[`CFG_POWER_UP_POLICY] |
     ((~power_on_policy_config_r[`CFG_PIN_RESP] | pin_asserted) &
      (~power_on_policy_config_r[`CFG_COMMAND_RESP] |
       operation_control_r[`OP_ON_BIT])));

  // output enable and stage settings come from flops
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_output_enable_r <= 1'b0;
      o_rise_sel_r <= `TON_IDX_RESET;
      o_margin_fault_act_r <= 1'b0;
    end else begin
      o_output_enable_r <= output_enable_nxt;
      o_rise_sel_r <= soft_start_idx_r;
      // act-on-fault variants have bit 1 of the field set and bit 0 clear
      o_margin_fault_act_r <= (margin_field == `MARGIN_LOW_ACT) |
                              (margin_field == `MARGIN_HIGH_ACT);
    end
  end

  // command register writes
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      power_on_policy_config_r <= `CFG_RESET;
      operation_control_r <= `OP_RESET;
      soft_start_idx_r <= `TON_IDX_RESET;
      output_divider_ratio_r <= `SCALE_MANT_RESET;
      output_offset_trim_r <= `TRIM_RESET;
      trim_bad_r <= 1'b0;
      margin_high_level_r <= `MARGIN_HIGH_RESET;
      margin_low_level_r <= `MARGIN_LOW_RESET;
      oc_warn_r <= `OC_WARN_RESET;
    end else if (wr) begin
      if (i_cmd_code == `CMD_OPERATION) begin
        operation_control_r <= i_cmd_data[7:0];
      end else if (i_cmd_code == `CMD_ON_OFF_CONFIG) begin
        // four writable bits, bit 0 stays set
        power_on_policy_config_r <= {i_cmd_data[4:1], 1'b1};
      end else if (i_cmd_code == `CMD_SOFT_START_TIME) begin
        if (rise_lookup[3]) begin
          soft_start_idx_r <= rise_lookup[2:0];
        end
      end else if (i_cmd_code == `CMD_SCALE_LOOP) begin
        if (scale_ok) begin
          output_divider_ratio_r <= i_cmd_data[10:0];
        end
      end else if (i_cmd_code == `CMD_VOUT_TRIM) begin
        // keep value, use zero if outside window
        output_offset_trim_r <= i_cmd_data;
        trim_bad_r <= ~trim_in_window;
      end else if (i_cmd_code == `CMD_MARGIN_HIGH) begin
        margin_high_level_r <= i_cmd_data[14:0];
      end else if (i_cmd_code == `CMD_MARGIN_LOW) begin
        margin_low_level_r <= i_cmd_data[14:0];
      end else if (i_cmd_code == `CMD_OC_WARN) begin
        oc_warn_r <= i_cmd_data[5:0];
      end
    end
  end

  // sticky status; a new event beats a clear in the same cycle
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cml_invalid_cmd_r <= 1'b0;
      cml_invalid_data_r <= 1'b0;
      temp_fault_r <= 1'b0;
      temp_warn_r <= 1'b0;
    end else begin
      // unknown code, read or write
      if (i_cmd_valid & ~known_cmd) begin
        cml_invalid_cmd_r <= 1'b1;
      end else if (clear_faults) begin
        cml_invalid_cmd_r <= 1'b0;
      end
      if (wr & (((i_cmd_code == `CMD_VOUT_TRIM) & ~trim_in_window) |
                ((i_cmd_code == `CMD_SOFT_START_TIME) & ~rise_lookup[3]) |
                ((i_cmd_code == `CMD_SCALE_LOOP) & ~scale_ok))) begin
        cml_invalid_data_r <= 1'b1;
      end else if (clear_faults) begin
        cml_invalid_data_r <= 1'b0;
      end
      if (i_ot_fault) begin
        temp_fault_r <= 1'b1;
      end else if (clear_faults) begin
        temp_fault_r <= 1'b0;
      end
      if (i_ot_warn) begin
        temp_warn_r <= 1'b1;
      end else if (clear_faults) begin
        temp_warn_r <= 1'b0;
      end
    end
  end

  assign status_cml = {cml_invalid_cmd_r, cml_invalid_data_r, 6'h00};
  assign status_temp = {temp_fault_r, temp_warn_r, 6'h00};
  assign status_byte = {5'h00, (temp_fault_r | temp_warn_r),
                        (cml_invalid_cmd_r | cml_invalid_data_r), 1'b0};

  // alert low while any status bit is set
  assign o_smbalert_n = ~(|status_byte);

  // fixed limit, 500 mA per count
  assign o_oc_warn_limit = (FIXED_OC_WARN != 0) ? `OC_WARN_FIXED : oc_warn_r;

  // read mux; unknown codes read as zero
  always @* begin
    rd_data_nxt = 16'h0000;
    if (i_cmd_code == `CMD_OPERATION) begin
      rd_data_nxt = {8'h00, operation_control_r};
    end else if (i_cmd_code == `CMD_ON_OFF_CONFIG) begin
      rd_data_nxt = {11'h000, power_on_policy_config_r};
    end else if (i_cmd_code == `CMD_SOFT_START_TIME) begin
      rd_data_nxt = {`EXP_SOFT_START_TIME, rise_mant(soft_start_idx_r)};
    end else if (i_cmd_code == `CMD_SCALE_LOOP) begin
      rd_data_nxt = {`EXP_SCALE_LOOP, output_divider_ratio_r};
    end else if (i_cmd_code == `CMD_VOUT_TRIM) begin
      rd_data_nxt = output_offset_trim_r;
    end else if (i_cmd_code == `CMD_MARGIN_HIGH) begin
      rd_data_nxt = {1'b0, margin_high_level_r};
    end else if (i_cmd_code == `CMD_MARGIN_LOW) begin
      rd_data_nxt = {1'b0, margin_low_level_r};
    end else if (i_cmd_code == `CMD_OC_WARN) begin
      // exponent over mantissa in one word
      rd_data_nxt = {`EXP_OC_WARN, 5'h00, o_oc_warn_limit};
    end else if (i_cmd_code == `CMD_STATUS_BYTE) begin
      rd_data_nxt = {8'h00, status_byte};
    end else if (i_cmd_code == `CMD_STATUS_TEMP) begin
      rd_data_nxt = {8'h00, status_temp};
    end else if (i_cmd_code == `CMD_STATUS_CML) begin
      rd_data_nxt = {8'h00, status_cml};
    end
  end

  // read answer one cycle after the request
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data_r <= 16'h0000;
      o_rd_valid_r <= 1'b0;
    end else begin
      o_rd_valid_r <= rd;
      if (rd) begin
        o_rd_data_r <= rd_data_nxt;
      end
    end
  end

  // reference target for the regulator
  vref_target u_vref (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_trim(trim_eff),
    .i_margin_level(margin_high ? margin_high_level_r : margin_low_level_r),
    .i_margin_low(margin_low),
    .i_margin_high(margin_high),
    .i_scale_mant(output_divider_ratio_r),
    .o_vref_r(o_vref_target)
  );

endmodule // pmbus_output_control

// *** hdl/pmbus_ctrl_consts.vh ***
`ifndef PMBUS_CTRL_CONSTS_VH
`define PMBUS_CTRL_CONSTS_VH

// command codes seen on the decoded command port
`define CMD_OPERATION 8'h01
`define CMD_ON_OFF_CONFIG 8'h02
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_VOUT_TRIM 8'h22
`define CMD_MARGIN_HIGH 8'h25
`define CMD_MARGIN_LOW 8'h26
`define CMD_SCALE_LOOP 8'h29
`define CMD_OC_WARN 8'h4a
`define CMD_SOFT_START_TIME 8'h61
`define CMD_STATUS_BYTE 8'h78
`define CMD_STATUS_TEMP 8'h7d
`define CMD_STATUS_CML 8'h7e

// on/off config field positions and reset value
`define CFG_POWER_UP_POLICY 4
`define CFG_COMMAND_RESP 3
`define CFG_PIN_RESP 2
`define CFG_PIN_POLARITY 1
`define CFG_PIN_ACTION 0
`define CFG_RESET 5'h17

// operation byte fields
`define OP_ON_BIT 7
`define OP_MARGIN_MSB 5
`define OP_MARGIN_LSB 2
`define OP_RESET 8'h00
`define MARGIN_LOW_IGNORE 4'h5
`define MARGIN_LOW_ACT 4'h6
`define MARGIN_HIGH_IGNORE 4'h9
`define MARGIN_HIGH_ACT 4'ha

// linear-format exponents, two's complement 5 bits
`define EXP_SOFT_START_TIME 5'h1c
`define EXP_SCALE_LOOP 5'h17
`define EXP_OC_WARN 5'h1f

// reset values of the word registers, ratio maximum and fixed warn limit
`define SCALE_MANT_RESET 11'h100
`define SCALE_MANT_MAX 11'h200
`define TON_IDX_RESET 3'h0
`define TRIM_RESET 16'h0000
`define MARGIN_HIGH_RESET 15'h0000
`define MARGIN_LOW_RESET 15'h0000
`define OC_WARN_RESET 6'h1d
`define OC_WARN_FIXED 6'h1d

// soft-start mantissas, 600us up to 9ms
`define TON_M0 11'h00a
`define TON_M1 11'h00e
`define TON_M2 11'h013
`define TON_M3 11'h01d
`define TON_M4 11'h02b
`define TON_M5 11'h043
`define TON_M6 11'h060
`define TON_M7 11'h090

// reference: 600 mV in units of 2^-19 V, and 25 % of it
`define VREF_NOM_CODE 28'h004_ccc_d
`define TRIM_WINDOW_LIM 27'h001_3333

// status bit positions
`define STB_TEMP 2
`define STB_CML 1
`define CML_INVALID_CMD 7
`define CML_INVALID_DATA 6
`define TEMP_OT_FAULT 7
`define TEMP_OT_WARN 6

`endif

// *** hdl/vref_target.v ***
`timescale 1ns/100ps
`include "pmbus_ctrl_consts.vh"

module vref_target (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // settings
  input wire [15:0] i_trim,
  input wire [14:0] i_margin_level,
  input wire i_margin_low,
  input wire i_margin_high,
  input wire [10:0] i_scale_mant,
  // reference code, units of 2^-19 V
  output reg [27:0] o_vref_r
);

  // margin level chosen by the operation byte
  wire [14:0] level_sel;
  // level plus trim, signed
  wire signed [16:0] sum;
  // either trim alone or level plus trim
  wire signed [16:0] offset;
  // offset scaled by the divider ratio
  wire signed [27:0] prod;
  wire [27:0] vref_nxt;

  assign level_sel = i_margin_high ? i_margin_level : i_margin_level;
  assign sum = $signed({2'b00, level_sel}) + $signed({i_trim[15], i_trim});
  assign offset = (i_margin_low | i_margin_high) ? sum :
                  $signed({i_trim[15], i_trim});
  assign prod = offset * $signed({6'h00, i_scale_mant});

  // the target is set by moving the reference, not the divider
  // nominal reference plus scaled offset, or the scaled offset alone when margining
  assign vref_nxt = (i_margin_low | i_margin_high) ? prod :
                    (`VREF_NOM_CODE + prod);

  // registered so the long multiply path ends in a flop
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_vref_r <= `VREF_NOM_CODE;
    end else begin
      o_vref_r <= vref_nxt;
    end
  end

endmodule // vref_target

// *** testbench/pmbus_output_control_sva.sv ***
`timescale 1ns/100ps
// checks seen only at the ports of the command block
module pmbus_output_control_sva #(
  parameter FIXED_OC_WARN = 1
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // command port
  input wire i_cmd_valid,
  input wire i_cmd_write,
  input wire [7:0] i_cmd_code,
  input wire [15:0] i_cmd_data,
  input wire [15:0] o_rd_data_r,
  input wire o_rd_valid_r,
  // pins
  input wire i_power_present,
  input wire i_onoff_pin,
  input wire i_ot_fault,
  input wire i_ot_warn,
  // power stage side
  input wire o_output_enable_r,
  input wire [27:0] o_vref_target,
  input wire [2:0] o_rise_sel_r,
  input wire [5:0] o_oc_warn_limit,
  input wire o_margin_fault_act_r,
  input wire o_smbalert_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // decoded request kinds
  wire rd_req = i_cmd_valid & ~i_cmd_write;
  wire wr_req = i_cmd_valid & i_cmd_write;
  wire op_wr = wr_req & (i_cmd_code == 8'h01);
  wire ton_wr = wr_req & (i_cmd_code == 8'h61);
  // margin mode code of an operation write
  wire [3:0] mcode = i_cmd_data[5:2];

  property p_rst_vals;
    $rose(i_rst_n) |-> o_vref_target == 28'h004cccd && !o_output_enable_r
      && o_smbalert_n && o_rise_sel_r == 3'h0;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("reset outputs wrong");
  property p_rd_pulse;
    rd_req |=> o_rd_valid_r;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read not answered");
  property p_rd_only;
    !rd_req |=> !o_rd_valid_r;
  endproperty
  a_rd_only: assert property (p_rd_only)
    else $error("read valid without read");
  property p_rd_hold;
    !rd_req |=> $stable(o_rd_data_r);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved");
  property p_no_power;
    !i_power_present [*3] |=> !o_output_enable_r;
  endproperty
  a_no_power: assert property (p_no_power)
    else $error("output on without power");
  property p_oc_fixed;
    FIXED_OC_WARN == 1 |-> o_oc_warn_limit == 6'h1d;
  endproperty
  a_oc_fixed: assert property (p_oc_fixed)
    else $error("warn limit not fixed");
  property p_clr_alert;
    wr_req && i_cmd_code == 8'h03 && !i_ot_fault && !i_ot_warn
      |=> o_smbalert_n;
  endproperty
  a_clr_alert: assert property (p_clr_alert)
    else $error("alert stuck after clear");
  property p_ton_bad;
    ton_wr && i_cmd_data[15:11] != 5'h1c |=> !o_smbalert_n;
  endproperty
  a_ton_bad: assert property (p_ton_bad)
    else $error("bad rise exponent not flagged");
  property p_ton_max;
    ton_wr && i_cmd_data == 16'he090 |-> ##2 o_rise_sel_r == 3'h7;
  endproperty
  a_ton_max: assert property (p_ton_max)
    else $error("9ms rise not selected");
  property p_act;
    op_wr && (mcode == 4'h6 || mcode == 4'ha) |-> ##2 o_margin_fault_act_r;
  endproperty
  a_act: assert property (p_act)
    else $error("act on fault not set");
  // main scenarios reached
  c_rd: cover property (rd_req);
  c_act: cover property (o_margin_fault_act_r);
  c_en: cover property ($rose(o_output_enable_r));
endmodule // pmbus_output_control_sva

bind pmbus_output_control pmbus_output_control_sva #(
  .FIXED_OC_WARN(FIXED_OC_WARN)
) i_sva (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
  .i_cmd_write(i_cmd_write), .i_cmd_code(i_cmd_code),
  .i_cmd_data(i_cmd_data), .o_rd_data_r(o_rd_data_r),
  .o_rd_valid_r(o_rd_valid_r), .i_power_present(i_power_present),
  .i_onoff_pin(i_onoff_pin), .i_ot_fault(i_ot_fault),
  .i_ot_warn(i_ot_warn), .o_output_enable_r(o_output_enable_r),
  .o_vref_target(o_vref_target), .o_rise_sel_r(o_rise_sel_r),
  .o_oc_warn_limit(o_oc_warn_limit),
  .o_margin_fault_act_r(o_margin_fault_act_r),
  .o_smbalert_n(o_smbalert_n)
);

// *** testbench/pmbus_master_model.sv ***
`timescale 1ns/100ps
// bus master stand-in, issuing commands as the framer would
module pmbus_master_model (
  // clock
  input wire i_clk,
  // command port toward the block
  output reg o_cmd_valid,
  output reg o_cmd_write,
  output reg [7:0] o_cmd_code,
  output reg [15:0] o_cmd_data,
  input wire [15:0] i_rd_data,
  input wire i_rd_valid
);
  // idle port at time zero
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_write = 1'b0;
    o_cmd_code = 8'h00;
    o_cmd_data = 16'h0000;
  end
  // released fields flip, so stale values never pass for fresh ones
  task release_port;
    begin
      o_cmd_valid = 1'b0;
      o_cmd_write = ~o_cmd_write;
      o_cmd_code = ~o_cmd_code;
      o_cmd_data = ~o_cmd_data;
    end
  endtask
  // words passed as given
  // words come packed {exponent, mantissa}; no check that trim and margin sums are legal
  task issue(input w, input [7:0] code, input [15:0] data);
    begin
      @(posedge i_clk);
      #1;
      o_cmd_valid = 1'b1;
      o_cmd_write = w;
      o_cmd_code = code;
      o_cmd_data = data;
      @(posedge i_clk);
      #1;
      release_port;
    end
  endtask
  // one write command
  task wr(input [7:0] code, input [15:0] data);
    issue(1'b1, code, data);
  endtask
  // one read; a missing answer returns inverted data
  task rd(input [7:0] code, output [15:0] data);
    begin
      issue(1'b0, code, 16'h0000);
      // answer stands from the edge after the request; take it settled
      data = i_rd_valid ? i_rd_data : ~i_rd_data;
    end
  endtask
endmodule // pmbus_master_model

// *** testbench/tb_pmbus_output_control.sv ***
`timescale 1ns/100ps
`include "pmbus_ctrl_consts.vh"
module tb_pmbus_output_control;
  // clock, reset and pins
  reg clk;
  reg rst_n;
  reg pwr;
  reg pin;
  reg ot_f;
  reg ot_w;
  // command port
  wire cv;
  wire cw;
  wire [7:0] cc;
  wire [15:0] cd;
  wire [15:0] rdd;
  wire rdv;
  // power stage side
  wire en;
  wire [27:0] vref;
  wire [2:0] rise;
  wire [5:0] ocl;
  wire fact;
  wire alert_n;
  // bookkeeping
  integer error_cnt;
  integer n_checks;
  integer i;
  reg [15:0] rv;
  // rise mantissas 600us..9ms, margin ops and expected {act, vref}
  reg [95:0] tont = 96'h00a00e01301d02b043060090;
  reg [39:0] opt = 40'h2428141_80c;
  reg [159:0] expt = {32'h00055000, 32'h10055000, 32'h00049000,
    32'h10049000, 32'h0004dccd};

  pmbus_master_model i_mst (
    .i_clk(clk), .o_cmd_valid(cv), .o_cmd_write(cw), .o_cmd_code(cc),
    .o_cmd_data(cd), .i_rd_data(rdd), .i_rd_valid(rdv)
  );
  pmbus_output_control #(
    .FIXED_OC_WARN(1)
  ) i_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_cmd_valid(cv), .i_cmd_write(cw),
    .i_cmd_code(cc), .i_cmd_data(cd), .o_rd_data_r(rdd),
    .o_rd_valid_r(rdv), .i_power_present(pwr), .i_onoff_pin(pin),
    .i_ot_fault(ot_f), .i_ot_warn(ot_w), .o_output_enable_r(en),
    .o_vref_target(vref), .o_rise_sel_r(rise), .o_oc_warn_limit(ocl),
    .o_margin_fault_act_r(fact), .o_smbalert_n(alert_n)
  );

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // compare and count
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // read a register and compare
  task rc(input [7:0] c, input [15:0] e);
    begin
      i_mst.rd(c, rv);
      chk(32'(rv), 32'(e));
    end
  endtask
  // let n edges pass, land just after the last
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  // clear sticky status
  task clr;
    begin
      i_mst.wr(`CMD_CLEAR_FAULTS, 16'h0000);
      cyc(1);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // watchdog, far beyond the two hundred or so cycles needed
  initial begin
    #500000;
    error_cnt = error_cnt + 1;
    finish_test;
  end

  initial begin
    error_cnt = 0;
    n_checks = 0;
    rst_n = 1'b0;
    pwr = 1'b0;
    pin = 1'b0;
    ot_f = 1'b0;
    ot_w = 1'b0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    chk(32'(vref), 32'h004cccd);
    chk(32'(ocl), 32'h1d);
    rc(`CMD_ON_OFF_CONFIG, 16'h0017);
    rc(`CMD_SCALE_LOOP, 16'hb900);
    rc(`CMD_SOFT_START_TIME, 16'he00a);
    $display("test reset done");
    // pin required by default, polarity high
    pwr = 1'b1;
    cyc(5);
    chk(32'(en), 32'h0);
    pin = 1'b1;
    cyc(5);
    chk(32'(en), 32'h1);
    pwr = 1'b0;
    cyc(5);
    chk(32'(en), 32'h0);
    pwr = 1'b1;
    pin = 1'b0;
    i_mst.wr(`CMD_ON_OFF_CONFIG, 16'h0006);
    cyc(5);
    chk(32'(en), 32'h1);
    rc(`CMD_ON_OFF_CONFIG, 16'h0007);
    // command response on, pin ignored
    i_mst.wr(`CMD_ON_OFF_CONFIG, 16'h0018);
    cyc(5);
    chk(32'(en), 32'h0);
    i_mst.wr(`CMD_OPERATION, 16'h0080);
    cyc(5);
    chk(32'(en), 32'h1);
    pin = 1'b1;
    i_mst.wr(`CMD_ON_OFF_CONFIG, 16'h0010);
    i_mst.wr(`CMD_OPERATION, 16'h0000);
    cyc(5);
    chk(32'(en), 32'h1);
    $display("test enable done");
    // every rise setting, then an illegal word
    for (i = 0; i < 8; i = i + 1) begin
      i_mst.wr(`CMD_SOFT_START_TIME, {5'h1c, tont[94-12*i -: 11]});
      cyc(2);
      chk(32'(rise), 32'(i[2:0]));
    end
    rc(`CMD_SOFT_START_TIME, 16'he090);
    i_mst.wr(`CMD_SOFT_START_TIME, 16'he00b);
    cyc(2);
    chk({28'h0, rise, alert_n}, 32'he);
    clr;
    chk(32'(alert_n), 32'h1);
    // wrong exponent with a listed mantissa is refused too
    i_mst.wr(`CMD_SOFT_START_TIME, 16'hd80a);
    cyc(2);
    chk({28'h0, rise, alert_n}, 32'he);
    clr;
    $display("test rise done");
    // trim up, down, and out of window
    i_mst.wr(`CMD_VOUT_TRIM, 16'h0100);
    cyc(2);
    chk(32'(vref), 32'h005cccd);
    i_mst.wr(`CMD_VOUT_TRIM, 16'hff00);
    cyc(2);
    chk(32'(vref), 32'h003cccd);
    i_mst.wr(`CMD_VOUT_TRIM, 16'h0200);
    cyc(2);
    chk({3'h0, alert_n, vref}, 32'h004cccd);
    rc(`CMD_VOUT_TRIM, 16'h0200);
    rc(`CMD_STATUS_BYTE, 16'h0002);
    rc(`CMD_STATUS_CML, 16'h0040);
    clr;
    $display("test trim done");
    // margin levels plus trim, each mode code
    i_mst.wr(`CMD_VOUT_TRIM, 16'h0010);
    i_mst.wr(`CMD_MARGIN_HIGH, 16'h0540);
    i_mst.wr(`CMD_MARGIN_LOW, 16'h0480);
    rc(`CMD_MARGIN_HIGH, 16'h0540);
    for (i = 0; i < 5; i = i + 1) begin
      i_mst.wr(`CMD_OPERATION, {8'h00, opt[39-8*i -: 8]});
      cyc(2);
      chk({3'h0, fact, vref}, expt[159-32*i -: 32]);
    end
    $display("test margin done");
    // divider ratio at its limit, then beyond it
    i_mst.wr(`CMD_SCALE_LOOP, 16'hba00);
    cyc(2);
    chk(32'(vref), 32'h004eccd);
    i_mst.wr(`CMD_SCALE_LOOP, 16'hba01);
    rc(`CMD_SCALE_LOOP, 16'hba00);
    clr;
    // warning limit holds its fixed value
    i_mst.wr(`CMD_OC_WARN, 16'hf83f);
    cyc(1);
    chk(32'(ocl), 32'h1d);
    rc(`CMD_OC_WARN, 16'hf81d);
    $display("test ratio and limit done");
    // temperature status, then an unknown code
    ot_w = 1'b1;
    cyc(1);
    ot_w = 1'b0;
    rc(`CMD_STATUS_TEMP, 16'h0040);
    ot_f = 1'b1;
    cyc(1);
    ot_f = 1'b0;
    rc(`CMD_STATUS_TEMP, 16'h00c0);
    rc(`CMD_STATUS_BYTE, 16'h0004);
    rc(8'h55, 16'h0000);
    rc(`CMD_STATUS_CML, 16'h0080);
    clr;
    chk(32'(alert_n), 32'h1);
    $display("test status done");
    finish_test;
  end
endmodule // tb_pmbus_output_control
